// *** logic/chg_limits_pkg.sv ***
// constants and carrier types for the minimum system voltage and host input current limit bank
// assumes a 16-bit word register port addressed by the even (low) byte offset
package chg_limits_pkg;
	// register byte offsets (low byte of each 16-bit pair)
	localparam logic [7:0] OFS_MIN_SYS_VOLT = 8'h0c;
	localparam logic [7:0] OFS_HOST_IIN_LIM = 8'h0e;

	// minimum system voltage field layout
	localparam int MSV_CODE_W      = 6;
	localparam int MSV_CODE_LSB    = 8;
	localparam int MSV_RSVD_MSB    = 15;
	localparam int MSV_RSVD_LSB    = 14;
	localparam int MSV_STEP_SHIFT  = 8; // 256 mV per code step
	localparam logic [5:0] MSV_CODE_MIN = 6'h04; // 1.024 V
	localparam logic [5:0] MSV_CODE_MAX = 6'h3f; // 16.128 V

	// power-on values of the minimum system voltage per cell count
	localparam logic [5:0] MSV_CODE_1S = 6'h0e; // 3.584 V
	localparam logic [5:0] MSV_CODE_2S = 6'h18; // 6.144 V
	localparam logic [5:0] MSV_CODE_3S = 6'h24; // 9.216 V
	localparam logic [5:0] MSV_CODE_4S = 6'h30; // 12.288 V

	// host input current limit field layout
	localparam int IIN_CODE_W   = 7;
	localparam int IIN_CODE_LSB = 8;
	localparam int IIN_RSVD_BIT = 15;
	localparam logic [15:0] IIN_RESET      = 16'h4100; // 3.3 A with offset
	localparam logic [15:0] IIN_STEP_MA    = 16'h0032; // 50 mA
	localparam logic [15:0] IIN_OFFSET_MA  = 16'h0032; // 50 mA at code zero

	// system rail headroom above battery while the path switch is off
	localparam logic [15:0] SYS_HEADROOM_MV = 16'h00a0; // 160 mV

	// cell count pin encodings
	typedef enum logic [1:0] {
		CELL_1S = 2'b00,
		CELL_2S = 2'b01,
		CELL_3S = 2'b11,
		CELL_4S = 2'b10
	} cell_count_t;

	// analog measurements handed in from the converter side
	typedef struct packed {
		logic [15:0] batt_mv;
		logic [15:0] vin_mv;
		logic [15:0] vin_lim_mv;
		logic [15:0] iin_ma;
	} meas_t;

	// regulation decisions handed out to the power stage
	typedef struct packed {
		logic        switch_linear;
		logic        switch_full_on;
		logic        switch_off;
		logic        charge_reduce;
		logic [15:0] sys_target_mv;
	} reg_mode_t;
endpackage : chg_limits_pkg

// *** logic/chg_reg_mode.sv ***
// regulation mode choice from battery, settings and input conditions
// purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module chg_reg_mode (
	input  wire logic [15:0]                i_min_sys_mv,
	input  wire logic [15:0]                i_iin_lim_ma,
	input  wire chg_limits_pkg::meas_t      i_meas,
	input  wire logic                       i_charging,
	input  wire logic                       i_supplement,
	output var  chg_limits_pkg::reg_mode_t  o_mode
);
	import chg_limits_pkg::*;

	logic [16:0] headroom_sum;

	// battery below floor, above it, and the input limit loop
	always_comb begin
		headroom_sum = {1'b0, i_meas.batt_mv} + {1'b0, SYS_HEADROOM_MV};
		o_mode = '0;
		if (i_meas.batt_mv < i_min_sys_mv) begin
			o_mode.switch_linear = 1'b1;
			o_mode.sys_target_mv = i_min_sys_mv;
		end else if (i_charging || i_supplement) begin
			o_mode.switch_full_on = 1'b1;
			o_mode.sys_target_mv  = i_meas.batt_mv;
		end else begin
			// off with headroom; saturate instead of wrapping
			o_mode.switch_off    = 1'b1;
			o_mode.sys_target_mv = headroom_sum[16] ? 16'hffff : headroom_sum[15:0];
		end
		o_mode.charge_reduce = (i_meas.iin_ma > i_iin_lim_ma) ||
			(i_meas.vin_mv < i_meas.vin_lim_mv);
	end
endmodule : chg_reg_mode
`default_nettype wire

// *** logic/chg_limits_regs.sv ***
// minimum system voltage and host input current limit registers with mode outputs
// assumes a word-wide register port decoded by an upstream serial slave, all inputs synchronous
`timescale 1ns/1ps
`default_nettype none
// Operation
// - floor voltage code in high bits 5:0
// - out-of-range floor writes are dropped
// - floor reloads from cell-count pin on the first edge after reset
// - floor code weights 256 mV per step
// - reserved floor bits set mean invalid write
// - floor low byte ignored, reads zero
// - battery below floor: switch linear mode
// - above floor: full on or 160 mV headroom
// - over-limit input reduces charge current
// - input limit 50 to 6400 mA steps
// - input limit defaults and resets on removal
// - input limit carries fixed 50 mA offset
// - limit pin unused when disabled or high
// - reserved bit7 stored, low byte read-only
module chg_limits_regs #(
	parameter int ADDR_W = 8
) (
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_sys_rst,
	input  wire logic                       i_clk_en,
	input  wire logic                       i_reg_wr,
	input  wire logic                       i_reg_rd,
	input  wire logic [ADDR_W-1:0]          i_reg_addr,
	input  wire logic [15:0]                i_reg_wdata,
	input  wire logic [1:0]                 i_cell_count_pin,
	input  wire logic                       i_adapter_present,
	input  wire logic                       i_charging,
	input  wire logic                       i_supplement,
	input  wire chg_limits_pkg::meas_t      i_meas,
	input  wire logic                       i_limit_pin_disable,
	input  wire logic                       i_limit_pin_above_4v,
	output logic [15:0]                     o_reg_rdata,
	output logic                            o_reg_rvalid,
	output logic                            o_wr_rejected,
	output logic [15:0]                     o_min_sys_mv,
	output logic [15:0]                     o_iin_lim_ma,
	output logic                            o_limit_pin_in_use,
	output chg_limits_pkg::reg_mode_t       o_mode
);
	import chg_limits_pkg::*;

	// elaboration check: the decode compares against 8-bit offsets
	if (ADDR_W < 8) begin : g_addr_w_check
		$error("ADDR_W must hold the 8-bit register offsets");
	end

	logic [MSV_CODE_W-1:0] msv_code_q, msv_code_d;
	logic [IIN_CODE_W-1:0] iin_code_q, iin_code_d;
	logic                  iin_rsvd_q, iin_rsvd_d;
	logic                  strap_done_q, strap_done_d;
	logic                  adapter_q, adapter_d;
	logic [15:0]           rdata_q, rdata_d;
	logic                  rvalid_q, rvalid_d;
	logic                  rejected_q, rejected_d;
	logic [15:0]           min_sys_mv_q, min_sys_mv_d;
	logic [15:0]           iin_lim_ma_q, iin_lim_ma_d;
	logic                  pin_use_q, pin_use_d;
	reg_mode_t             mode_q;
	reg_mode_t             mode_c;

	logic [MSV_CODE_W-1:0] wr_msv_code;
	logic                  wr_msv_sel;
	logic                  wr_iin_sel;
	logic                  msv_valid;
	logic                  adapter_removed;
	logic [MSV_CODE_W-1:0] strap_code;
	logic [15:0]           iin_lim_calc;
	logic [15:0]           floor_mv;

	// address decode; anything outside the two offsets is ignored
	// a write to an unmapped offset is dropped without a rejection pulse
	assign wr_msv_sel  = i_reg_wr && (i_reg_addr == ADDR_W'(OFS_MIN_SYS_VOLT));
	assign wr_iin_sel  = i_reg_wr && (i_reg_addr == ADDR_W'(OFS_HOST_IIN_LIM));
	assign wr_msv_code = i_reg_wdata[MSV_CODE_LSB +: MSV_CODE_W];

	// range check, 1.024 to 16.128 V
	assign msv_valid = (i_reg_wdata[MSV_RSVD_MSB:MSV_RSVD_LSB] == 2'b00) &&
		(wr_msv_code >= MSV_CODE_MIN) && (wr_msv_code <= MSV_CODE_MAX);

	// falling edge of the adapter present level
	// adapter_q resets low, so no false removal follows reset
	assign adapter_removed = adapter_q && !i_adapter_present;

	always_comb begin
		unique case (cell_count_t'(i_cell_count_pin))
			CELL_1S: strap_code = MSV_CODE_1S;
			CELL_2S: strap_code = MSV_CODE_2S;
			CELL_3S: strap_code = MSV_CODE_3S;
			CELL_4S: strap_code = MSV_CODE_4S;
		endcase
	end

	// applied limit is code steps plus offset
	assign iin_lim_calc = 16'((iin_code_q * IIN_STEP_MA) + IIN_OFFSET_MA);

	// floor in mV, binary weights of 256 mV
	assign floor_mv = 16'(msv_code_q) << MSV_STEP_SHIFT;

	// next state of the setting registers
	// the strap load owns the first edge after reset, so an early
	// floor write is lost rather than queued; the host waits a cycle
	always_comb begin
		msv_code_d   = msv_code_q;
		iin_code_d   = iin_code_q;
		iin_rsvd_d   = iin_rsvd_q;
		strap_done_d = 1'b1;
		adapter_d    = i_adapter_present;
		rejected_d   = 1'b0;
		if (!strap_done_q) begin
			msv_code_d = strap_code;
		end else if (wr_msv_sel) begin
			// keep old value on bad write
			if (msv_valid) begin
				msv_code_d = wr_msv_code;
			end
			rejected_d = !msv_valid;
		end
		// removal restores the default; wins over a host write
		if (adapter_removed) begin
			iin_code_d = IIN_RESET[IIN_CODE_LSB +: IIN_CODE_W];
			iin_rsvd_d = IIN_RESET[IIN_RSVD_BIT];
		end else if (wr_iin_sel) begin
			iin_code_d = i_reg_wdata[IIN_CODE_LSB +: IIN_CODE_W];
			iin_rsvd_d = i_reg_wdata[IIN_RSVD_BIT];
		end
	end

	// read path and registered outputs
	// a read in the same cycle as a write shows the old value
	always_comb begin
		rdata_d  = rdata_q;
		rvalid_d = i_reg_rd;
		if (i_reg_rd) begin
			if (i_reg_addr == ADDR_W'(OFS_MIN_SYS_VOLT)) begin
				// low byte and reserved bits read zero
				rdata_d = {2'b00, msv_code_q, 8'h00};
			end else if (i_reg_addr == ADDR_W'(OFS_HOST_IIN_LIM)) begin
				rdata_d = {iin_rsvd_q, iin_code_q, 8'h00};
			end else begin
				rdata_d = 16'h0000;
			end
		end
		min_sys_mv_d = floor_mv;
		iin_lim_ma_d = iin_lim_calc;
		// pin used only when enabled and low
		pin_use_d    = !i_limit_pin_disable && !i_limit_pin_above_4v;
	end

	// settings state; reset values are constants, strap loads after release
	// loading the strap inside reset would put a pin in the reset branch
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			msv_code_q   <= MSV_CODE_1S;
			iin_code_q   <= IIN_RESET[IIN_CODE_LSB +: IIN_CODE_W];
			iin_rsvd_q   <= IIN_RESET[IIN_RSVD_BIT];
			strap_done_q <= 1'b0;
			adapter_q    <= 1'b0;
			rejected_q   <= 1'b0;
		end else if (i_clk_en) begin
			msv_code_q   <= msv_code_d;
			iin_code_q   <= iin_code_d;
			iin_rsvd_q   <= iin_rsvd_d;
			strap_done_q <= strap_done_d;
			adapter_q    <= adapter_d;
			rejected_q   <= rejected_d;
		end
	end

	// output flops; mode lags measurements by one cycle
	// data outputs come from flops, so nothing downstream sees a glitch
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rdata_q      <= 16'h0000;
			rvalid_q     <= 1'b0;
			min_sys_mv_q <= 16'h0000;
			iin_lim_ma_q <= 16'h0000;
			pin_use_q    <= 1'b0;
			mode_q       <= '0;
		end else if (i_clk_en) begin
			rdata_q      <= rdata_d;
			rvalid_q     <= rvalid_d;
			min_sys_mv_q <= min_sys_mv_d;
			iin_lim_ma_q <= iin_lim_ma_d;
			pin_use_q    <= pin_use_d;
			mode_q       <= mode_c;
		end
	end

	// mode decision uses the live settings, not the lagging outputs
	chg_reg_mode u_reg_mode (
		.i_min_sys_mv (floor_mv),
		.i_iin_lim_ma (iin_lim_calc),
		.i_meas       (i_meas),
		.i_charging   (i_charging),
		.i_supplement (i_supplement),
		.o_mode       (mode_c)
	);

	// ports are plain views of the flops
	assign o_reg_rdata        = rdata_q;
	assign o_reg_rvalid       = rvalid_q;
	assign o_wr_rejected      = rejected_q;
	assign o_min_sys_mv       = min_sys_mv_q;
	assign o_iin_lim_ma       = iin_lim_ma_q;
	assign o_limit_pin_in_use = pin_use_q;
	assign o_mode             = mode_q;
endmodule : chg_limits_regs
`default_nettype wire

// *** dv/host_model.sv ***
// host model driving word writes and reads on the register port
// assumes one request at a time, launched just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic        i_sys_clk,
	output var  logic        o_wr,
	output var  logic        o_rd,
	output var  logic [7:0]  o_addr,
	output var  logic [15:0] o_wdata
);
	// idle bus at time zero
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 16'h0000;
	end
	// one word transfer; strobes drop low and address and data are inverted so stale data never looks valid
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		o_wr <= w;
		o_rd <= ~w;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_sys_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask : xfer
endmodule : host_model
`default_nettype wire

// *** dv/chg_limits_checker.sv ***
// port checker for the floor voltage and input limit bank
// assumes the clock enable is held high by the bench
`timescale 1ns/1ps
`default_nettype none
module chg_limits_checker
	import chg_limits_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic              i_sys_clk,
	input wire logic              i_sys_rst,
	input wire logic              i_reg_wr,
	input wire logic              i_reg_rd,
	input wire logic [ADDR_W-1:0] i_reg_addr,
	input wire logic [15:0]       i_reg_wdata,
	input wire logic              i_adapter_present,
	input wire logic              i_charging,
	input wire logic              i_supplement,
	input wire meas_t             i_meas,
	input wire logic              i_limit_pin_disable,
	input wire logic              i_limit_pin_above_4v,
	input wire logic [15:0]       o_reg_rdata,
	input wire logic              o_reg_rvalid,
	input wire logic              o_wr_rejected,
	input wire logic [15:0]       o_min_sys_mv,
	input wire logic [15:0]       o_iin_lim_ma,
	input wire logic              o_limit_pin_in_use,
	input wire reg_mode_t         o_mode
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_sys_rst);
	// helper views of the stimulus
	wire [15:0] batt = i_meas.batt_mv;
	wire [6:0]  iin_code = i_reg_wdata[14:8];
	// cycles since reset; the strap load moves the floor with no write
	logic [1:0] settle_q;
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			settle_q <= 2'h0;
		end else if (settle_q != 2'h3) begin
			settle_q <= settle_q + 2'h1;
		end
	end
	// a floor write on the strap edge is lost by design
	sequence floor_wr;
		i_reg_wr && i_reg_addr == ADDR_W'(OFS_MIN_SYS_VOLT) && settle_q != 2'h0;
	endsequence
	sequence iin_wr;
		i_reg_wr && i_reg_addr == ADDR_W'(OFS_HOST_IIN_LIM) && i_adapter_present;
	endsequence
	// three write-free cycles so the floor output matches the stored floor
	sequence quiet;
		!i_reg_wr [*3];
	endsequence
	bad_floor_a:
		assert property (floor_wr ##0 (i_reg_wdata[15:14] != 2'b00
			|| i_reg_wdata[13:8] < MSV_CODE_MIN) |=> o_wr_rejected)
		else $error("bad floor word not rejected");
	good_floor_a:
		assert property (floor_wr ##0 (i_reg_wdata[15:14] == 2'b00 && i_reg_wdata[13:8] >= MSV_CODE_MIN)
			|=> !o_wr_rejected ##1 o_min_sys_mv == ($past(i_reg_wdata, 2) & 16'h3f00))
		else $error("floor write not applied");
	iin_set_a:
		assert property (iin_wr ##1 i_adapter_present
			|=> o_iin_lim_ma == 16'($past(iin_code, 2)) * 16'h0032 + 16'h0032)
		else $error("input limit write not applied");
	removal_a:
		assert property ($fell(i_adapter_present) |-> ##[1:3] o_iin_lim_ma == 16'h0ce4)
		else $error("input limit kept after removal");
	read_low_a:
		assert property (i_reg_rd |=> o_reg_rvalid && o_reg_rdata[7:0] == 8'h00)
		else $error("read answer wrong");
	pin_free_a:
		assert property ((i_limit_pin_disable || i_limit_pin_above_4v) |=> !o_limit_pin_in_use)
		else $error("limit pin used while released");
	linear_mode_a:
		assert property (quiet ##0 settle_q == 2'h3 && batt < o_min_sys_mv
			|=> o_mode.switch_linear && o_mode.sys_target_mv == $past(o_min_sys_mv))
		else $error("linear mode missing");
	headroom_a:
		assert property (quiet ##0 settle_q == 2'h3 && batt >= o_min_sys_mv && batt < 16'hff60
			&& !i_charging && !i_supplement
			|=> o_mode.switch_off && o_mode.sys_target_mv == $past(batt) + 16'h00a0)
		else $error("headroom target wrong");
	reduce_a:
		assert property (i_meas.vin_mv < i_meas.vin_lim_mv |=> o_mode.charge_reduce)
		else $error("charge not reduced");
endmodule : chg_limits_checker
bind chg_limits_regs chg_limits_checker #(.ADDR_W(ADDR_W)) chk_u (.i_sys_clk, .i_sys_rst,
	.i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_adapter_present, .i_charging,
	.i_supplement, .i_meas, .i_limit_pin_disable, .i_limit_pin_above_4v, .o_reg_rdata,
	.o_reg_rvalid, .o_wr_rejected, .o_min_sys_mv, .o_iin_lim_ma, .o_limit_pin_in_use, .o_mode);
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the floor voltage and input limit bank
// assumes the host model in dv/ and the checker bound to the design
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import chg_limits_pkg::*;
	logic i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_clk_en = 1'b1, i_adapter_present = 1'b1;
	logic i_charging = 1'b0, i_supplement = 1'b0, i_limit_pin_disable = 1'b0;
	logic i_limit_pin_above_4v = 1'b0, i_reg_wr, i_reg_rd, o_reg_rvalid, o_wr_rejected;
	logic [1:0] i_cell_count_pin = 2'b00;
	logic [7:0] i_reg_addr;
	logic [15:0] i_reg_wdata, o_reg_rdata, o_min_sys_mv, o_iin_lim_ma, fl_w, iin_w, w, lim;
	logic o_limit_pin_in_use;
	meas_t i_meas = '0, m;
	reg_mode_t o_mode;
	int n_fail = 0, samples_checked = 0;
	logic [15:0] corner [8] = '{16'h03ff, 16'h0000, 16'h04aa, 16'hff00,
		16'h4400, 16'h7f55, 16'h3f00, 16'h0100};
	always #10 i_sys_clk = ~i_sys_clk;
	chg_limits_regs #(.ADDR_W(8)) dut_u (.i_sys_clk, .i_sys_rst, .i_clk_en, .i_reg_wr, .i_reg_rd,
		.i_reg_addr, .i_reg_wdata, .i_cell_count_pin, .i_adapter_present, .i_charging,
		.i_supplement, .i_meas, .i_limit_pin_disable, .i_limit_pin_above_4v, .o_reg_rdata,
		.o_reg_rvalid, .o_wr_rejected, .o_min_sys_mv, .o_iin_lim_ma, .o_limit_pin_in_use, .o_mode);
	host_model host_u (.i_sys_clk, .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr),
		.o_wdata(i_reg_wdata));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic results;
		$display("compares %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		host_u.xfer(1'b0, a, 16'h0000);
		@(posedge i_sys_clk);
		#1;
		check(o_reg_rdata, e);
	endtask : rd_chk
	// power-on floor per strap, equal to the readback word
	function automatic logic [15:0] strap_mv(input logic [1:0] c);
		case (c)
			2'b00: return 16'h0e00;
			2'b01: return 16'h1800;
			2'b11: return 16'h2400;
			default: return 16'h3000;
		endcase
	endfunction : strap_mv
	// expected regulation choice; saturates the headroom target
	function automatic reg_mode_t mode_exp(input logic [15:0] fl, input logic [15:0] lm,
		input meas_t x, input logic busy);
		reg_mode_t r;
		r = '0;
		r.charge_reduce = (x.iin_ma > lm) || (x.vin_mv < x.vin_lim_mv);
		r.switch_linear = x.batt_mv < fl;
		r.switch_full_on = !r.switch_linear && busy;
		r.switch_off = !r.switch_linear && !busy;
		r.sys_target_mv = r.switch_linear ? fl : r.switch_full_on ? x.batt_mv
			: (x.batt_mv > 16'hff5f) ? 16'hffff : x.batt_mv + 16'h00a0;
		return r;
	endfunction : mode_exp
	// watchdog cuts a hang short
	initial begin
		#200_000;
		n_fail++;
		results();
	end
	// main sequence: strap resets, random writes with corners, mode, removal
	initial begin
		void'($urandom(60));
		for (int c = 0; c < 4; c++) begin
			// later passes reset in mid-run, launched on an edge
			if (c != 0) begin
				@(posedge i_sys_clk);
			end
			i_cell_count_pin <= 2'(c);
			i_sys_rst <= 1'b1;
			repeat (3) @(posedge i_sys_clk);
			i_sys_rst <= 1'b0;
			repeat (3) @(posedge i_sys_clk);
			#1;
			check(o_min_sys_mv, strap_mv(2'(c)));
			check(o_iin_lim_ma, 16'h0ce4);
			rd_chk(OFS_MIN_SYS_VOLT, strap_mv(2'(c)));
			rd_chk(OFS_HOST_IIN_LIM, 16'h4100);
		end
		// the last strap pass was the three-cell code
		fl_w = strap_mv(2'b11);
		iin_w = 16'h4100;
		for (int i = 0; i < 48; i++) begin
			w = (i < 8) ? corner[i] : 16'($urandom());
			host_u.xfer(1'b1, i[0] ? OFS_HOST_IIN_LIM : OFS_MIN_SYS_VOLT, w);
			#1;
			// floor under 1.024 V or with a reserved bit set is discarded
			check(o_wr_rejected, !i[0] && (w[15:14] != 2'b00 || w[13:8] < 6'h04));
			if (i[0])
				iin_w = w & 16'hff00;
			else if (w[15:14] == 2'b00 && w[13:8] >= 6'h04)
				fl_w = w & 16'h3f00;
			rd_chk(i[0] ? OFS_HOST_IIN_LIM : OFS_MIN_SYS_VOLT, i[0] ? iin_w : fl_w);
			lim = 16'(iin_w[14:8]) * 16'h0032 + 16'h0032;
			m = {fl_w - 16'h0100 + 16'($urandom_range(0, 511)), 16'($urandom()),
				16'($urandom()), lim - 16'h0032 + 16'($urandom_range(0, 100))};
			@(posedge i_sys_clk);
			i_meas <= m;
			{i_charging, i_supplement, i_limit_pin_disable, i_limit_pin_above_4v} <= 4'($urandom());
			repeat (2) @(posedge i_sys_clk);
			#1;
			check(o_mode, mode_exp(fl_w, lim, m, i_charging || i_supplement));
			check(o_min_sys_mv, fl_w);
			check(o_iin_lim_ma, lim);
			check(o_limit_pin_in_use, !(i_limit_pin_disable || i_limit_pin_above_4v));
		end
		// the no-switch setup registers sit outside this bank
		// host leaves a low limit before the adapter goes away
		host_u.xfer(1'b1, OFS_HOST_IIN_LIM, 16'h0500);
		@(posedge i_sys_clk);
		i_adapter_present <= 1'b0;
		#1;
		check(o_iin_lim_ma, 16'h012c);
		repeat (4) @(posedge i_sys_clk);
		#1;
		check(o_iin_lim_ma, 16'h0ce4);
		rd_chk(OFS_HOST_IIN_LIM, 16'h4100);
		rd_chk(8'h10, 16'h0000);
		results();
	end
endmodule : testbench
`default_nettype wire
